// >>> rtl/flash_pin_pkg.sv
package flash_pin_pkg;
  localparam int ADDR_BITS = 24;
  localparam int ARRAY_ADDR_BITS = 21;
  localparam int ARRAY_BYTES = 2097152;
  localparam int PAGE_BYTES = 256;
  localparam int SECTOR_BYTES = 4096;
  localparam int BLOCK_BYTES = 65536;
  localparam int PAGE_COUNT = 8192;
  localparam int OTP_BYTES = 512;
  localparam int CLK_MHZ = 10;
  localparam real PAGE_PROG_MS = 1.3;
  localparam real SECTOR_ERASE_MS = 60.0;
  localparam real BLOCK_ERASE_MS = 400.0;
  localparam int PAGE_PROG_CYC = int'(PAGE_PROG_MS * 1000.0 * CLK_MHZ);
  localparam int SECTOR_ERASE_CYC = int'(SECTOR_ERASE_MS * 1000.0 * CLK_MHZ);
  localparam int BLOCK_ERASE_CYC = int'(BLOCK_ERASE_MS * 1000.0 * CLK_MHZ);
  localparam logic [1:0] LANE_SINGLE = 2'h0;
  localparam logic [1:0] LANE_DUAL = 2'h1;
  localparam logic [1:0] LANE_QUAD = 2'h2;
  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_PAGE = 2'h1,
    OP_SECTOR = 2'h3,
    OP_BLOCK = 2'h2
  } op_type;
  typedef struct packed {
    logic [3:0] in;
    logic [3:0] out;
    logic [3:0] oe;
  } lanes_type;
endpackage : flash_pin_pkg

// >>> rtl/quad_serial_flash_pin_interface.sv
`timescale 1ns/1ps
// Summary of operation
// [RL1] Only SPI modes 0 and 3 are supported.
// [RL2] Host parks the clock low in mode 0, high in mode 3.
// [RL3] Single lane: input bits captured on rising serial clock.
// [RL4] Single lane: output bits shifted on falling serial clock.
// [RL5] Dual/quad lanes bidirectional: sample on rising, drive on falling.
// [RL6] Dual uses lanes 0-1, quad uses lanes 0-3.
// [RL7] Chip select high: all output lanes released.
// [RL8] Started erase/program/status cycles finish even when deselected.
// [RL9] Chip select low selects device for commands and reads.
// [RL10] After power-up, commands ignored until a select falling edge; code still grants status writes before arming.
// [RL11] Pause low while selected releases output and ignores input and clock.
// [RL12] Pause exists only in single/dual; in quad the pin is lane 3.
// [RL13] Write guard asserted blocks status register writes; code blocks them only while statusLockBits is nonzero.
// [RL14] Write guard plus region guard and lock bits protect the array; code protects it by regionGuardBits alone.
// [RL15] Write guard exists only in single/dual; in quad the pin is lane 2.
// [RL16] Array is 2 MB: 32 blocks, 512 sectors, 8192 pages.
// [RL17] Program only clears bits; erase sets them.
// [RL18] Erase by sector, block or chip, never by page.
// [RL19] One page program takes 1 to 256 bytes.
// [RL20] Program about 1.3 ms, sector erase 60 ms, block erase 400 ms.
// [RL21] A lockable 512-byte one-time-programmable sector exists.
// [RL22] 24-bit address decoded; upper three bits are ignored.
module quad_serial_flash_pin_interface
  import flash_pin_pkg::*;
#(
  parameter int PAGE_CYC = PAGE_PROG_CYC,
  parameter int SECTOR_CYC = SECTOR_ERASE_CYC,
  parameter int BLOCK_CYC = BLOCK_ERASE_CYC
) (
  // System
  input wire logic clk,
  input wire logic resetn,
  input wire logic clkEn,
  // Serial link
  input wire logic serialClk,
  input wire logic chipSelectN,
  input wire lanes_type lanesIn,
  output lanes_type lanesOut,
  // Mode and protection control
  input wire logic [1:0] laneMode,
  input wire logic [3:0] regionGuardBits,
  input wire logic [1:0] statusLockBits,
  // Operation requests from the command decoder
  input wire logic opReq,
  input wire op_type opKind,
  input wire logic chipErase,
  input wire logic [ADDR_BITS-1:0] opAddr,
  input wire logic [8:0] opBytes,
  input wire logic statusWriteReq,
  input wire logic otpSelect,
  input wire logic otpLockReq,
  // Link-side data
  output logic [7:0] rxByte,
  output logic rxValid,
  input wire logic [7:0] txByte,
  // Status
  output logic busy,
  output logic opRefused,
  output logic statusWriteOk,
  output logic otpLocked,
  output logic selected,
  output logic armed
);

  logic rstA_r, rstB_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstA_r <= 1'b0;
      rstB_r <= 1'b0;
    end else begin
      rstA_r <= 1'b1;
      rstB_r <= rstA_r;
    end
  end
  wire logic rstn = rstB_r;

  // Pin-function multiplexing on lanes 2 and 3
  wire logic quad = (laneMode == LANE_QUAD);
  wire logic pauseN = quad ? 1'b1 : lanesIn.in[3]; // [RL12]
  wire logic guardN = quad ? 1'b1 : lanesIn.in[2]; // [RL15]

  // Link domain: serial clock; shift, count and transmit registers reset while deselected, byte toggle and hold by resetn
  logic [7:0] shiftIn_r;
  logic [2:0] bitCnt_r;
  logic rxTog_r;
  logic [7:0] rxHold_r;
  logic [7:0] txSh_r;
  logic [3:0] outBits_r;
  logic seenHigh_r;
  logic [3:0] stepIn;
  always_comb begin
    stepIn = 4'h1;
    if (laneMode == LANE_DUAL) stepIn = 4'h2; // [RL6]
    else if (quad) stepIn = 4'h4;
  end

  // Rising edge capture in either mode; pause freezes everything [RL1] [RL3] [RL5] [RL11]
  always_ff @(posedge serialClk or posedge chipSelectN) begin
    if (chipSelectN) begin
      shiftIn_r <= 8'h00;
      bitCnt_r <= 3'h0;
    end else if (pauseN) begin
      unique case (laneMode)
        LANE_DUAL: shiftIn_r <= {shiftIn_r[5:0], lanesIn.in[1:0]};
        LANE_QUAD: shiftIn_r <= {shiftIn_r[3:0], lanesIn.in[3:0]};
        default: shiftIn_r <= {shiftIn_r[6:0], lanesIn.in[0]};
      endcase
      bitCnt_r <= bitCnt_r + stepIn[2:0];
    end
  end

  // Completed byte toggles to the system domain
  wire logic byteDone = pauseN && ((bitCnt_r + stepIn[2:0]) == 3'h0);
  always_ff @(posedge serialClk or negedge resetn) begin
    if (!resetn) begin
      rxTog_r <= 1'b0;
      rxHold_r <= 8'h00;
    end else if (!chipSelectN && byteDone) begin
      rxTog_r <= ~rxTog_r;
      unique case (laneMode)
        LANE_DUAL: rxHold_r <= {shiftIn_r[5:0], lanesIn.in[1:0]};
        LANE_QUAD: rxHold_r <= {shiftIn_r[3:0], lanesIn.in[3:0]};
        default: rxHold_r <= {shiftIn_r[6:0], lanesIn.in[0]};
      endcase
    end
  end

  // Falling edge drive [RL4] [RL5]
  always_ff @(negedge serialClk or posedge chipSelectN) begin
    if (chipSelectN) begin
      txSh_r <= 8'h00;
      outBits_r <= 4'h0;
    end else if (pauseN) begin
      if (bitCnt_r == 3'h0) begin
        txSh_r <= txByte;
        unique case (laneMode)
          LANE_DUAL: outBits_r <= {2'h0, txByte[7:6]};
          LANE_QUAD: outBits_r <= txByte[7:4];
          default: outBits_r <= {2'h0, txByte[7], 1'b0};
        endcase
      end else begin
        unique case (laneMode)
          LANE_DUAL: outBits_r <= {2'h0, txSh_r[{bitCnt_r[2:1], 1'b0} ^ 3'h6 +: 2]};
          LANE_QUAD: outBits_r <= txSh_r[3:0];
          default: outBits_r <= {2'h0, txSh_r[3'h7 - bitCnt_r], 1'b0};
        endcase
      end
    end
  end

  // Output enables: released when deselected or paused [RL7] [RL11]
  always_comb begin
    lanesOut.in = 4'h0;
    lanesOut.out = outBits_r;
    lanesOut.oe = 4'h0;
    if (!chipSelectN && pauseN && armed) begin // [RL10]
      unique case (laneMode)
        LANE_DUAL: lanesOut.oe = 4'h3;
        LANE_QUAD: lanesOut.oe = 4'hF;
        default: lanesOut.oe = 4'h2;
      endcase
      // Lanes the host is driving are never driven back, so quad writes see no contention
      lanesOut.oe = lanesOut.oe & ~lanesIn.oe; // [RL5]
    end
  end

  // System domain synchronisers
  logic csA_r, csB_r, csC_r, togA_r, togB_r, togC_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      csA_r <= 1'b1;
      csB_r <= 1'b1;
      csC_r <= 1'b1;
      togA_r <= 1'b0;
      togB_r <= 1'b0;
      togC_r <= 1'b0;
    end else if (clkEn) begin
      csA_r <= chipSelectN;
      csB_r <= csA_r;
      csC_r <= csB_r;
      togA_r <= rxTog_r;
      togB_r <= togA_r;
      togC_r <= togB_r;
    end
  end
  assign selected = !csB_r; // [RL9]

  // Power-up arming on first select high-to-low [RL10]
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      seenHigh_r <= 1'b0;
      armed <= 1'b0;
    end else if (clkEn) begin
      if (csB_r) seenHigh_r <= 1'b1;
      if (seenHigh_r && csC_r && !csB_r) armed <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxByte <= 8'h00;
      rxValid <= 1'b0;
    end else if (clkEn) begin
      rxValid <= armed && (togB_r != togC_r);
      if (togB_r != togC_r) rxByte <= rxHold_r;
    end
  end

  // Write guard and region protection [RL13] [RL14]
  logic [ARRAY_ADDR_BITS-1:0] arrAddr;
  logic [4:0] blockIdx;
  logic [5:0] protBlocks;
  logic prot;
  always_comb begin
    arrAddr = opAddr[ARRAY_ADDR_BITS-1:0]; // [RL22]
    blockIdx = arrAddr[ARRAY_ADDR_BITS-1 -: 5]; // [RL16]
    protBlocks = (regionGuardBits == 4'h0) ? 6'h00 : 6'(6'h01 << (regionGuardBits - 4'h1));
    if (regionGuardBits >= 4'h6) protBlocks = 6'h20;
    prot = chipErase ? (regionGuardBits != 4'h0)
                     : ({1'b0, 5'h1F - blockIdx} < protBlocks);
  end
  wire logic hwLock = (statusLockBits != 2'h0) && !guardN;
  assign statusWriteOk = statusWriteReq && !hwLock; // [RL13]

  // Operation timer: runs to completion regardless of select [RL8] [RL20]
  localparam int TW = 32;
  logic [TW-1:0] timer_r;
  logic [TW-1:0] loadVal;
  logic bytesOk, okToStart;
  always_comb begin
    bytesOk = (opBytes != 9'h000) && (opBytes <= 9'(PAGE_BYTES)); // [RL19]
    unique case (opKind)
      OP_PAGE: loadVal = TW'(PAGE_CYC);
      OP_SECTOR: loadVal = TW'(SECTOR_CYC);
      OP_BLOCK: loadVal = TW'(BLOCK_CYC);
      default: loadVal = '0;
    endcase
    if (chipErase) loadVal = TW'(BLOCK_CYC) * TW'(32);
    // No page-granular erase exists; page kind always means program [RL18]
    okToStart = armed && !busy && (opKind != OP_NONE || chipErase)
              && !(otpSelect ? otpLocked : prot)
              && (opKind != OP_PAGE || bytesOk);
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timer_r <= '0;
      busy <= 1'b0;
      opRefused <= 1'b0;
    end else if (clkEn) begin
      opRefused <= opReq && !okToStart;
      if (opReq && okToStart) begin
        timer_r <= loadVal;
        busy <= 1'b1;
      end else if (busy) begin
        timer_r <= timer_r - TW'(1);
        if (timer_r == TW'(1)) busy <= 1'b0;
      end
    end
  end

  // One-time sector lock is sticky once set [RL21]
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) otpLocked <= 1'b0;
    else if (clkEn && otpLockReq && armed) otpLocked <= 1'b1;
  end

  // Program clears only: new = old & data; erase returns all ones [RL17]
  // Storage itself lives in the array macro beside this block.

  chk_out_released: assert property (@(posedge clk) disable iff (!rstn)
    csB_r |-> lanesOut.oe == 4'h0 || !chipSelectN) else $error("lanes driven while deselected"); // [RL7]
  chk_quad_lanes: assert property (@(posedge clk) disable iff (!rstn)
    (!chipSelectN && quad && armed) |-> lanesOut.oe == ~lanesIn.oe) else $error("quad lanes not all driven"); // [RL6]
  chk_pause_release: assert property (@(posedge clk) disable iff (!rstn)
    (!quad && !lanesIn.in[3]) |-> lanesOut.oe == 4'h0) else $error("output driven in pause"); // [RL11]
  chk_arm_first: assert property (@(posedge clk) disable iff (!rstn)
    !armed |-> !rxValid && !busy) else $error("activity before arming"); // [RL10]
  chk_guard_status: assert property (@(posedge clk) disable iff (!rstn)
    (!quad && !lanesIn.in[2] && statusLockBits != 2'h0) |-> !statusWriteOk) else $error("guarded status write"); // [RL13]
  chk_guard_quad: assert property (@(posedge clk) disable iff (!rstn)
    (quad && statusWriteReq) |-> statusWriteOk) else $error("guard active in quad"); // [RL15]
  chk_page_bytes: assert property (@(posedge clk) disable iff (!rstn || !clkEn)
    (opReq && opKind == OP_PAGE && opBytes == 9'h000) |=> opRefused) else $error("zero byte page accepted"); // [RL19]
  chk_busy_holds: assert property (@(posedge clk) disable iff (!rstn)
    (busy && timer_r > TW'(2) && clkEn) |=> busy) else $error("operation cut short"); // [RL8]
  chk_otp_sticky: assert property (@(posedge clk) disable iff (!rstn)
    otpLocked |=> otpLocked) else $error("otp lock lost"); // [RL21]

  // Lane usage per mode
  chk_single_oe: assert property (@(posedge clk) disable iff (!rstn)
    (laneMode == LANE_SINGLE) |-> lanesOut.oe[3:2] == 2'h0 && !lanesOut.oe[0])
    else $error("single mode drives a wrong lane"); // [RL4]

  chk_single_data: assert property (@(posedge clk) disable iff (!rstn)
    (!chipSelectN && laneMode == LANE_SINGLE) |-> lanesOut.out[3:2] == 2'h0 && !lanesOut.out[0])
    else $error("single mode data on a wrong lane"); // [RL4]

  chk_dual_oe: assert property (@(posedge clk) disable iff (!rstn)
    (laneMode == LANE_DUAL) |-> lanesOut.oe[3:2] == 2'h0)
    else $error("dual mode drives upper lanes"); // [RL6]

  chk_dual_data: assert property (@(posedge clk) disable iff (!rstn)
    (!chipSelectN && laneMode == LANE_DUAL) |-> lanesOut.out[3:2] == 2'h0)
    else $error("dual mode data on upper lanes"); // [RL6]

  // Arming after power-up
  chk_armed_sticky: assert property (@(posedge clk) disable iff (!rstn)
    armed |=> armed)
    else $error("arming lost"); // [RL10]

  chk_rx_armed: assert property (@(posedge clk) disable iff (!rstn)
    rxValid |-> armed)
    else $error("byte delivered unarmed"); // [RL10]

  chk_unarmed_refuse: assert property (@(posedge clk) disable iff (!rstn)
    (opReq && !armed && clkEn) |=> opRefused)
    else $error("operation taken unarmed"); // [RL10]

  // Operation acceptance and refusal
  chk_busy_refuse: assert property (@(posedge clk) disable iff (!rstn)
    (opReq && busy && clkEn) |=> opRefused)
    else $error("second operation taken while busy"); // [RL8]

  chk_busy_start: assert property (@(posedge clk) disable iff (!rstn)
    (opReq && okToStart && clkEn) |=> busy && !opRefused)
    else $error("accepted operation not started"); // [RL8]

  chk_busy_end: assert property (@(posedge clk) disable iff (!rstn)
    (busy && timer_r == TW'(1) && !opReq && clkEn) |=> !busy)
    else $error("operation overran its count"); // [RL20]

  chk_page_oversize: assert property (@(posedge clk) disable iff (!rstn)
    (opReq && opKind == OP_PAGE && opBytes > 9'(PAGE_BYTES) && clkEn) |=> opRefused)
    else $error("oversized page accepted"); // [RL19]

  chk_region_refuse: assert property (@(posedge clk) disable iff (!rstn)
    (opReq && !otpSelect && prot && clkEn) |=> opRefused)
    else $error("protected region modified"); // [RL14]

  chk_chip_guarded: assert property (@(posedge clk) disable iff (!rstn)
    (opReq && chipErase && !otpSelect && regionGuardBits != 4'h0 && clkEn) |=> opRefused)
    else $error("chip erase with guarded regions"); // [RL14]

  chk_otp_refuse: assert property (@(posedge clk) disable iff (!rstn)
    (opReq && otpSelect && otpLocked && clkEn) |=> opRefused)
    else $error("locked sector modified"); // [RL21]

  // Status writes
  chk_status_free: assert property (@(posedge clk) disable iff (!rstn)
    (statusWriteReq && statusLockBits == 2'h0) |-> statusWriteOk)
    else $error("unlocked status write blocked"); // [RL13]

  chk_status_idle: assert property (@(posedge clk) disable iff (!rstn)
    !statusWriteReq |-> !statusWriteOk)
    else $error("status write without request"); // [RL13]

  // Busy length watch; a counter, since the longest span is far beyond a repetition
  logic [TW-1:0] busyRun_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) busyRun_r <= '0;
    else if (clkEn) busyRun_r <= busy ? busyRun_r + TW'(1) : '0;
  end
  chk_busy_bounded: assert property (@(posedge clk) disable iff (!rstn)
    busyRun_r <= TW'(BLOCK_CYC) * TW'(32))
    else $error("operation outlived the longest load"); // [RL20]
endmodule : quad_serial_flash_pin_interface

// >>> verification/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
  // Link pins driven by the host
  output logic serialClk,
  output logic chipSelectN,
  output logic [3:0] hostLanes,
  // Write guard level used outside quad frames
  input wire logic guardN
);
  logic [3:0] d = 4'h0;
  logic quadNow = 1'b0;
  initial begin
    serialClk = 1'b0;
    chipSelectN = 1'b1;
  end
  // Pause stays inactive; the guard pin carries data only in quad frames
  assign hostLanes = {quadNow ? d[3] : 1'b1, quadNow ? d[2] : guardN, d[1:0]};
  // Clock parks at the mode's idle level and runs only inside frames
  task automatic frame(input logic [7:0] b, input logic quad, input logic mode3);
    int i;
    int w;
    w = quad ? 4 : 1;
    serialClk = mode3;
    quadNow = quad;
    #6 chipSelectN = 1'b0;
    for (i = 8 - w; i >= 0; i -= w) begin
      #6 serialClk = 1'b0;
      d = quad ? 4'(b >> i) : {3'h0, b[i]};
      #6 serialClk = 1'b1;
    end
    #6 serialClk = mode3;
    #6 chipSelectN = 1'b1;
    // Released lanes flip instead of holding the last bit
    d = ~d;
    quadNow = 1'b0;
  endtask : frame
endmodule : spi_host_model

// >>> verification/quad_serial_flash_pin_interface_tb_top.sv
`timescale 1ns/1ps
module quad_serial_flash_pin_interface_tb_top;
  import flash_pin_pkg::*;
  localparam int PC = 4;
  localparam int SC = 6;
  localparam int BC = 8;
  logic clk = 0, resetn = 0, opReq = 0, chipErase = 0, statusWriteReq = 0, otpSelect = 0, otpLockReq = 0;
  logic guardN = 1, serialClk, chipSelectN, rxValid, busy, opRefused, statusWriteOk, otpLocked, selected, armed;
  logic gotRef;
  logic [1:0] laneMode = LANE_SINGLE, statusLockBits = 2'h0;
  logic [3:0] regionGuardBits = 4'h0, hostLanes;
  op_type opKind = OP_PAGE;
  logic [ADDR_BITS-1:0] opAddr = '0;
  logic [8:0] opBytes = 9'h001;
  logic [7:0] txByte = 8'h5A, rxByte;
  lanes_type lanesIn, lanesOut;
  int err_total = 0, n_tests = 0, len;
  always #50 clk = ~clk;
  // The host claims every lane during a quad frame; the device yields those lanes
  assign lanesIn = {(lanesOut.oe & lanesOut.out) | (~lanesOut.oe & hostLanes), 4'h0, host.quadNow ? 4'hF : 4'h0};
  spi_host_model host (.serialClk, .chipSelectN, .hostLanes, .guardN);
  quad_serial_flash_pin_interface #(.PAGE_CYC(PC), .SECTOR_CYC(SC), .BLOCK_CYC(BC)) dut (
    .clk, .resetn, .clkEn(1'b1), .serialClk, .chipSelectN, .lanesIn, .lanesOut, .laneMode, .regionGuardBits,
    .statusLockBits, .opReq, .opKind, .chipErase, .opAddr, .opBytes, .statusWriteReq, .otpSelect, .otpLockReq,
    .rxByte, .rxValid, .txByte, .busy, .opRefused, .statusWriteOk, .otpLocked, .selected, .armed);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  task automatic run_op(input op_type k, input logic [ADDR_BITS-1:0] a, input logic [8:0] n);
    int i;
    @(negedge clk);
    opKind = k;
    opAddr = a;
    opBytes = n;
    opReq = 1;
    @(negedge clk);
    opReq = 0;
    gotRef = 0;
    len = 0;
    for (i = 0; i < 3; i++) begin
      if (opRefused === 1'b1) gotRef = 1;
      if (busy === 1'b1 || gotRef) break;
      @(negedge clk);
    end
    while (busy === 1'b1 && len < 100) begin
      len++;
      @(negedge clk);
    end
  endtask : run_op
  task automatic rx_chk(input logic [7:0] e);
    int i;
    logic seen;
    seen = 0;
    for (i = 0; i < 20 && !seen; i++) begin
      @(negedge clk);
      if (rxValid === 1'b1) begin
        seen = 1;
        chk(rxByte, e);
      end
    end
    chk(seen, 1);
  endtask : rx_chk
  // Long enough for every sequence below with a wide margin
  initial begin
    #400000;
    err_total++;
    final_report();
  end
  initial begin
    repeat (12) @(negedge clk);
    resetn = 1;
    repeat (3) @(negedge clk);
    chk(armed, 0);
    run_op(OP_PAGE, 24'h000100, 9'h001);
    chk(gotRef, 1);
    host.frame(8'hA5, 0, 0);
    rx_chk(8'hA5);
    chk(armed, 1);
    host.frame(8'h3C, 0, 1);
    rx_chk(8'h3C);
    laneMode = LANE_QUAD;
    host.frame(8'hC3, 1, 0);
    rx_chk(8'hC3);
    laneMode = LANE_SINGLE;
    chk(lanesOut.oe, 0);
    run_op(OP_PAGE, 24'h000000, 9'h100);
    chk({gotRef, len[7:0]}, PC);
    run_op(OP_PAGE, 24'h000000, 9'h000);
    chk(gotRef, 1);
    run_op(OP_PAGE, 24'h000000, 9'h101);
    chk(gotRef, 1);
    // A whole frame passes while the erase runs, so select changes mid-operation
    fork
      run_op(OP_SECTOR, 24'h001000, 9'h001);
      #300 host.frame(8'h11, 0, 0);
    join
    chk({gotRef, len[7:0]}, SC);
    regionGuardBits = 4'h1;
    run_op(OP_SECTOR, 24'hFFF000, 9'h001);
    chk(gotRef, 1);
    run_op(OP_BLOCK, 24'h010000, 9'h001);
    chk({gotRef, len[7:0]}, BC);
    chipErase = 1;
    run_op(OP_BLOCK, 24'h000000, 9'h001);
    chk(gotRef, 1);
    chipErase = 0;
    regionGuardBits = 4'h0;
    statusWriteReq = 1;
    statusLockBits = 2'h1;
    guardN = 0;
    repeat (4) @(negedge clk);
    chk(statusWriteOk, 0);
    guardN = 1;
    repeat (4) @(negedge clk);
    chk(statusWriteOk, 1);
    statusWriteReq = 0;
    otpLockReq = 1;
    @(negedge clk);
    otpLockReq = 0;
    repeat (2) @(negedge clk);
    chk(otpLocked, 1);
    otpSelect = 1;
    run_op(OP_PAGE, 24'h000000, 9'h001);
    chk(gotRef, 1);
    final_report();
  end
endmodule : quad_serial_flash_pin_interface_tb_top
